/* File: logic/pmvt_pkg.sv */
// Purpose: Shared constants and types of the program memory and vector unit
// Assumes: One 125 MHz clock; the instruction cycle is four clocks long
// Notes:   Addresses are in program words or data-memory bytes
package pmvt_pkg;
   // Memory shape
   localparam int PMVT_AW    = 12;
   localparam int PMVT_PW    = 15;
   localparam int PMVT_DW    = 8;
   localparam int PMVT_DEPTH = 4096;
   localparam int PMVT_GP_SIZE = 160;
   // Fixed entry points
   localparam logic [11:0] PMVT_VEC_RESET = 12'h000;
   localparam logic [11:0] PMVT_VEC_EXT   = 12'h004;
   localparam logic [11:0] PMVT_VEC_TMR0  = 12'h008;
   localparam logic [11:0] PMVT_VEC_TMR1  = 12'h00c;
   localparam logic [3:0]  PMVT_LAST_PAGE = 4'hf;
   // Data memory locations
   localparam logic [7:0] PMVT_ADDR_PC_LOW     = 8'h06;
   localparam logic [7:0] PMVT_ADDR_TABLE_PTR  = 8'h07;
   localparam logic [7:0] PMVT_ADDR_TABLE_HIGH = 8'h08;
   localparam logic [7:0] PMVT_GP_BASE         = 8'h60;
   // Reset values and counts
   localparam logic [7:0] PMVT_TABLE_PTR_RST = 8'h00;
   localparam logic [2:0] PMVT_STACK_LEVELS  = 3'h6;
   localparam logic [1:0] PMVT_CYC_LAST      = 2'h3;
   localparam logic [4:0] PMVT_SER_READ_TURN = 5'h0c;
   localparam logic [4:0] PMVT_SER_FRAME_END = 5'h1b;
   // Program-counter commands issued by the core once per instruction cycle
   typedef enum logic [2:0] {
      PMVT_OP_NEXT, PMVT_OP_SKIP, PMVT_OP_JUMP, PMVT_OP_CALL, PMVT_OP_RETURN,
      PMVT_OP_TABLE_READ_CURRENT, PMVT_OP_TABLE_READ_LAST
   } pmvt_op_t;
   // ALU functions
   typedef enum logic [3:0] {
      PMVT_ALU_ADD, PMVT_ALU_ADC, PMVT_ALU_SUB, PMVT_ALU_SBC, PMVT_ALU_AND,
      PMVT_ALU_OR, PMVT_ALU_XOR, PMVT_ALU_CPL, PMVT_ALU_RR, PMVT_ALU_RL,
      PMVT_ALU_RRC, PMVT_ALU_RLC, PMVT_ALU_INC, PMVT_ALU_DEC
   } pmvt_alu_t;
endpackage

/* File: logic/pmvt_tbl_if.sv */
// Purpose: Link between the unit core and its table-read sequencer
// Assumes: Both ends on ref_clk
// Notes:   The core owns the program store; the sequencer owns the high latch
`timescale 1ns/100ps
interface pmvt_tbl_if;
   logic        start;
   logic        last_page;
   logic [3:0]  pc_hi;
   logic [7:0]  table_ptr;
   logic [11:0] rd_addr;
   logic [14:0] rd_word;
   logic        done;
   logic [7:0]  low_byte;
   logic [7:0]  table_high_byte_latch;
   modport core (output start, last_page, pc_hi, table_ptr, rd_word,
                 input rd_addr, done, low_byte, table_high_byte_latch);
   modport seq  (input start, last_page, pc_hi, table_ptr, rd_word,
                 output rd_addr, done, low_byte, table_high_byte_latch);
endinterface

/* File: logic/pmvt_table_read.sv */
// Purpose: Two-cycle table read: form the address, then capture the word
// Assumes: cyc_en marks instruction-cycle boundaries
// Notes:   The latch is only loaded here, so program writes never reach it
`timescale 1ns/100ps
module pmvt_table_read
   import pmvt_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic cyc_en,
   // Core side
   pmvt_tbl_if.seq   tb
);
   logic        busy_q;
   logic [11:0] addr_q;
   logic        done_q;
   logic [7:0]  low_q;
   logic [7:0]  high_q;

   assign tb.rd_addr               = addr_q;
   assign tb.done                  = done_q;
   assign tb.low_byte              = low_q;
   assign tb.table_high_byte_latch = high_q;

   // First cycle forms the address, second cycle captures the word
   always_ff @(posedge ref_clk)
   begin
      done_q <= 1'b0;
      if (reset)
      begin
         busy_q <= 1'b0;
         addr_q <= PMVT_VEC_RESET;
      end
      else if (cyc_en && busy_q)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b1;
      end
      else if (cyc_en && tb.start)
      begin
         busy_q <= 1'b1;
         addr_q <= {(tb.last_page ? PMVT_LAST_PAGE : tb.pc_hi), tb.table_ptr};
      end
   end

   // Split the fetched word into low byte and high latch
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         low_q  <= 8'h00;
         high_q <= 8'h00;
      end
      else if (cyc_en && busy_q)
      begin
         low_q  <= tb.rd_word[7:0];
         high_q <= {1'b0, tb.rd_word[14:8]};
      end
   end

   a_last_page_addr : assert property (@(posedge ref_clk) disable iff (reset)
      cyc_en && tb.start && !busy_q && tb.last_page |=> addr_q[11:8] == 4'hf)
      else $error("last page table read not on final page");
   a_high_latch_load : assert property (@(posedge ref_clk) disable iff (reset)
      cyc_en && busy_q |=> high_q[6:0] == $past(tb.rd_word[14:8]) && done_q)
      else $error("high latch missed fetched upper bits");
endmodule

/* File: logic/pmvt_top.sv */
// Purpose: Program store, program counter, vectors, table reads, ALU status
// Assumes: Core commands are steady across each instruction cycle
// Notes:   Behaviour rules follow, one per line
`timescale 1ns/100ps
module pmvt_top
   import pmvt_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Core commands
   input  wire pmvt_op_t    op,
   input  wire logic [11:0] op_addr,
   input  wire logic [7:0]  op_dest,
   output      logic        cyc_en,
   output      logic        busy,
   output      logic [11:0] pc_q,
   output      logic [14:0] fetch_word_q,
   // Data memory port
   input  wire logic        dm_we,
   input  wire logic [7:0]  dm_addr,
   input  wire logic [7:0]  dm_wdata,
   output      logic [7:0]  dm_rdata_q,
   // ALU
   input  wire logic        alu_go,
   input  wire pmvt_alu_t   alu_op,
   input  wire logic        alu_to_mem,
   input  wire logic [7:0]  alu_dest,
   output      logic [7:0]  acc_q,
   output      logic [3:0]  status_q,
   // Interrupt sources
   input  wire logic        ext_int_n,
   input  wire logic        ext_int_en,
   input  wire logic        tmr0_ovf,
   input  wire logic        tmr0_int_en,
   input  wire logic        tmr1_ovf,
   input  wire logic        tmr1_int_en,
   // Programming port
   input  wire logic        external_reset_pin_n,
   input  wire logic        prog_serial_clock_pin,
   input  wire logic        prog_serial_data_pin_i,
   output      logic        prog_serial_data_pin_o,
   output      logic        prog_serial_data_pin_oe
);
   typedef enum logic [1:0] {PMVT_ST_RUN, PMVT_ST_DUMMY, PMVT_ST_TABLE} pmvt_state_t;

   logic [14:0] pmem_q [0:PMVT_DEPTH-1];
   logic [7:0]  gp_q [0:PMVT_GP_SIZE-1];
   logic [11:0] stack_q [0:5];
   logic [2:0]  sp_q;
   logic [1:0]  cyc_cnt_q;
   pmvt_state_t state_q;
   logic [7:0]  table_ptr_q;
   logic [7:0]  tbl_dest_q;
   logic        ext_prev_q, flag_ext_q, flag_t0_q, flag_t1_q;
   logic        prog_mode, stack_full, pc_low_wr, run_slot;
   logic        go_ext, go_t0, go_t1, go_irq;
   logic [11:0] vec;
   logic [7:0]  wr_addr, wr_data, alu_b;
   logic        wr_en;
   logic [8:0]  alu_r;
   logic        alu_ac;
   logic        sclk_prev_q, oe_q;
   logic [4:0]  ser_cnt_q;
   logic [27:0] ser_sh_q, ser_new;
   logic [14:0] ser_out_q;

   // Table-read sequencer and the link that carries its traffic
   pmvt_tbl_if tb ();
   pmvt_table_read i_pmvt_table_read (.ref_clk(ref_clk), .reset(reset), .cyc_en(cyc_en), .tb(tb));

   // Data memory read, general area first
   function automatic logic [7:0] dm_read(input logic [7:0] a);
      logic [7:0] idx;
      idx = a - PMVT_GP_BASE;
      if (a >= PMVT_GP_BASE) return gp_q[idx];
      case (a)
         PMVT_ADDR_PC_LOW:     return pc_q[7:0];
         PMVT_ADDR_TABLE_PTR:  return table_ptr_q;
         PMVT_ADDR_TABLE_HIGH: return tb.table_high_byte_latch;
         default:              return 8'h00;
      endcase
   endfunction

   // Instruction-cycle divider
   always_ff @(posedge ref_clk)
   begin
      if (reset) cyc_cnt_q <= 2'h0;
      else cyc_cnt_q <= cyc_cnt_q + 2'h1;
   end
   assign cyc_en = (cyc_cnt_q == PMVT_CYC_LAST);

   assign prog_mode  = !external_reset_pin_n;
   assign stack_full = (sp_q == PMVT_STACK_LEVELS);
   assign busy       = (state_q != PMVT_ST_RUN);
   assign run_slot   = cyc_en && !prog_mode && state_q == PMVT_ST_RUN;
   assign pc_low_wr  = run_slot && dm_we && dm_addr == PMVT_ADDR_PC_LOW;

   // Interrupt selection, lowest vector wins
   assign go_irq = run_slot && !pc_low_wr && op == PMVT_OP_NEXT && !stack_full;
   assign go_ext = go_irq && flag_ext_q && ext_int_en;
   assign go_t0  = go_irq && !go_ext && flag_t0_q && tmr0_int_en;
   assign go_t1  = go_irq && !go_ext && !go_t0 && flag_t1_q && tmr1_int_en;
   assign vec    = go_ext ? PMVT_VEC_EXT : (go_t0 ? PMVT_VEC_TMR0 : PMVT_VEC_TMR1);

   // Request flags; a new event beats the acknowledge clear
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ext_prev_q <= 1'b1;
         flag_ext_q <= 1'b0;
         flag_t0_q  <= 1'b0;
         flag_t1_q  <= 1'b0;
      end
      else
      begin
         ext_prev_q <= ext_int_n;
         flag_ext_q <= (ext_prev_q && !ext_int_n) || (flag_ext_q && !go_ext);
         flag_t0_q  <= tmr0_ovf || (flag_t0_q && !go_t0);
         flag_t1_q  <= tmr1_ovf || (flag_t1_q && !go_t1);
      end
   end

   // Program counter, stack and sequencing
   always_ff @(posedge ref_clk)
   begin
      if (reset || prog_mode)
      begin
         pc_q    <= PMVT_VEC_RESET;
         sp_q    <= 3'h0;
         state_q <= PMVT_ST_RUN;
      end
      else if (cyc_en)
      begin
         case (state_q)
            PMVT_ST_RUN:
            begin
               if (pc_low_wr)
               begin
                  pc_q    <= {pc_q[11:8], dm_wdata};
                  state_q <= PMVT_ST_DUMMY;
               end
               else if (go_ext || go_t0 || go_t1)
               begin
                  stack_q[sp_q] <= pc_q;
                  sp_q    <= sp_q + 3'h1;
                  pc_q    <= vec;
                  state_q <= PMVT_ST_DUMMY;
               end
               else
               begin
                  case (op)
                     PMVT_OP_SKIP:
                     begin
                        pc_q    <= pc_q + 12'h002;
                        state_q <= PMVT_ST_DUMMY;
                     end
                     PMVT_OP_JUMP:
                     begin
                        pc_q    <= op_addr;
                        state_q <= PMVT_ST_DUMMY;
                     end
                     PMVT_OP_CALL:
                     begin
                        if (!stack_full)
                        begin
                           stack_q[sp_q] <= pc_q + 12'h001;
                           sp_q <= sp_q + 3'h1;
                        end
                        pc_q    <= op_addr;
                        state_q <= PMVT_ST_DUMMY;
                     end
                     PMVT_OP_RETURN:
                     begin
                        if (sp_q != 3'h0)
                        begin
                           pc_q <= stack_q[sp_q - 3'h1];
                           sp_q <= sp_q - 3'h1;
                        end
                        state_q <= PMVT_ST_DUMMY;
                     end
                     PMVT_OP_TABLE_READ_CURRENT, PMVT_OP_TABLE_READ_LAST:
                     begin
                        pc_q    <= pc_q + 12'h001;
                        state_q <= PMVT_ST_TABLE;
                     end
                     default: pc_q <= pc_q + 12'h001;
                  endcase
               end
            end
            PMVT_ST_DUMMY: state_q <= PMVT_ST_RUN;
            PMVT_ST_TABLE: state_q <= PMVT_ST_RUN;
            default:       state_q <= PMVT_ST_RUN;
         endcase
      end
   end

   // Table-read hookup
   assign tb.start     = run_slot && !pc_low_wr && !go_ext && !go_t0 && !go_t1 &&
                         (op == PMVT_OP_TABLE_READ_CURRENT || op == PMVT_OP_TABLE_READ_LAST);
   assign tb.last_page = (op == PMVT_OP_TABLE_READ_LAST);
   assign tb.pc_hi     = pc_q[11:8];
   assign tb.table_ptr = table_ptr_q;
   assign tb.rd_word   = pmem_q[tb.rd_addr];

   // Instruction fetch
   always_ff @(posedge ref_clk)
   begin
      if (reset) fetch_word_q <= 15'h0000;
      else if (cyc_en) fetch_word_q <= pmem_q[pc_q];
   end

   // ALU operand, result and flags
   always_comb alu_b = dm_read(alu_dest);                        // Follows memory writes too
   always_comb
   begin
      alu_r  = 9'h000;
      alu_ac = 1'b0;
      case (alu_op)
         PMVT_ALU_ADD: alu_r = {1'b0, acc_q} + {1'b0, alu_b};
         PMVT_ALU_ADC: alu_r = {1'b0, acc_q} + {1'b0, alu_b} + {8'h00, status_q[0]};
         PMVT_ALU_SUB: alu_r = {1'b0, acc_q} + {1'b0, ~alu_b} + 9'h001;
         PMVT_ALU_SBC: alu_r = {1'b0, acc_q} + {1'b0, ~alu_b} + {8'h00, status_q[0]};
         PMVT_ALU_AND: alu_r = {status_q[0], acc_q & alu_b};
         PMVT_ALU_OR:  alu_r = {status_q[0], acc_q | alu_b};
         PMVT_ALU_XOR: alu_r = {status_q[0], acc_q ^ alu_b};
         PMVT_ALU_CPL: alu_r = {status_q[0], ~alu_b};
         PMVT_ALU_RR:  alu_r = {status_q[0], alu_b[0], alu_b[7:1]};
         PMVT_ALU_RL:  alu_r = {status_q[0], alu_b[6:0], alu_b[7]};
         PMVT_ALU_RRC: alu_r = {alu_b[0], status_q[0], alu_b[7:1]};
         PMVT_ALU_RLC: alu_r = {alu_b[7], alu_b[6:0], status_q[0]};
         PMVT_ALU_INC: alu_r = {status_q[0], alu_b + 8'h01};
         PMVT_ALU_DEC: alu_r = {status_q[0], alu_b - 8'h01};
         default:      alu_r = {status_q[0], acc_q};
      endcase
      alu_ac = (alu_op <= PMVT_ALU_SBC) && (acc_q[4] ^ alu_b[4] ^ alu_r[4]);
   end

   // Accumulator and status: {overflow, aux carry, zero, carry}
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         acc_q    <= 8'h00;
         status_q <= 4'h0;
      end
      else if (run_slot && alu_go)
      begin
         if (!alu_to_mem) acc_q <= alu_r[7:0];
         status_q <= {alu_r[7] ^ alu_r[8] ^ acc_q[7] ^ alu_b[7], alu_ac,
                      alu_r[7:0] == 8'h00, alu_r[8]};
      end
   end

   // Data memory write port: table result, then ALU, then program
   assign wr_en   = tb.done || (run_slot && alu_go && alu_to_mem) || (run_slot && dm_we);
   assign wr_addr = tb.done ? tbl_dest_q : ((alu_go && alu_to_mem) ? alu_dest : dm_addr);
   assign wr_data = tb.done ? tb.low_byte : ((alu_go && alu_to_mem) ? alu_r[7:0] : dm_wdata);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         table_ptr_q <= PMVT_TABLE_PTR_RST;
         tbl_dest_q  <= 8'h00;
      end
      else
      begin
         if (tb.start) tbl_dest_q <= op_dest;
         if (wr_en && wr_addr == PMVT_ADDR_TABLE_PTR) table_ptr_q <= wr_data;
      end
   end

   // General area storage; the high latch has no write path here
   always_ff @(posedge ref_clk)
   begin
      if (wr_en && wr_addr >= PMVT_GP_BASE) gp_q[wr_addr - PMVT_GP_BASE] <= wr_data;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset) dm_rdata_q <= 8'h00;
      else dm_rdata_q <= dm_read(dm_addr);
   end

   // Serial programming: flag, 12 address bits, 15 data bits, MSB first
   assign ser_new = {ser_sh_q[26:0], prog_serial_data_pin_i};
   always_ff @(posedge ref_clk)
   begin
      if (reset || !prog_mode)
      begin
         sclk_prev_q <= 1'b0;
         ser_cnt_q   <= 5'h00;
         ser_sh_q    <= 28'h0000000;
         ser_out_q   <= 15'h0000;
         oe_q        <= 1'b0;
      end
      else
      begin
         sclk_prev_q <= prog_serial_clock_pin;
         if (prog_serial_clock_pin && !sclk_prev_q)
         begin
            ser_sh_q  <= ser_new;
            ser_cnt_q <= ser_cnt_q + 5'h01;
            if (ser_cnt_q == PMVT_SER_READ_TURN && !ser_new[12])
            begin
               ser_out_q <= pmem_q[ser_new[11:0]];
               oe_q      <= 1'b1;
            end
            if (ser_cnt_q == PMVT_SER_FRAME_END)
            begin
               ser_cnt_q <= 5'h00;
               oe_q      <= 1'b0;
            end
         end
         // The first read bit must stand until the host's next rise, so the turn fall does not shift
         else if (!prog_serial_clock_pin && sclk_prev_q && oe_q && ser_cnt_q != PMVT_SER_READ_TURN + 5'h01)
            ser_out_q <= {ser_out_q[13:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (prog_mode && prog_serial_clock_pin && !sclk_prev_q &&
          ser_cnt_q == PMVT_SER_FRAME_END && ser_new[27])
         pmem_q[ser_new[26:15]] <= ser_new[14:0];
   end
   assign prog_serial_data_pin_o  = ser_out_q[14];
   assign prog_serial_data_pin_oe = oe_q;

   // Table read: four quiet clocks after the take, then the result strobe
   sequence s_table_wait;
      !tb.done [*4] ##1 tb.done;
   endsequence
   // Rest of the dummy cycle after a low-byte jump
   sequence s_dummy_rest;
      busy [*3] ##1 !busy;
   endsequence
   a_reset_vector : assert property (@(posedge ref_clk) reset |=> pc_q == 12'h000)
      else $error("counter not at reset vector");
   a_ext_vector : assert property (@(posedge ref_clk) disable iff (reset) go_ext |=> pc_q == 12'h004)
      else $error("external entry wrong");
   a_tmr0_vector : assert property (@(posedge ref_clk) disable iff (reset)
      go_irq && flag_t0_q && tmr0_int_en && !(flag_ext_q && ext_int_en) |=> pc_q == 12'h008)
      else $error("timer 0 entry wrong");
   a_tmr1_vector : assert property (@(posedge ref_clk) disable iff (reset)
      go_t1 |=> pc_q == 12'h00c && flag_t1_q == $past(tmr1_ovf))
      else $error("timer 1 entry wrong");
   a_table_two_cycles : assert property (@(posedge ref_clk) disable iff (reset)
      tb.start |=> s_table_wait)
      else $error("table read not two cycles");
   a_high_read_only : assert property (@(posedge ref_clk) disable iff (reset)
      !tb.done ##1 !tb.done |-> $stable(tb.table_high_byte_latch))
      else $error("high latch changed without table read");
   a_low_byte_jump : assert property (@(posedge ref_clk) disable iff (reset || prog_mode)
      pc_low_wr |=> (pc_q == {$past(pc_q[11:8]), $past(dm_wdata)} && busy) ##1 s_dummy_rest)
      else $error("low byte jump wrong");
   a_full_stack_hold : assert property (@(posedge ref_clk) disable iff (reset || prog_mode)
      run_slot && op == PMVT_OP_NEXT && !pc_low_wr && stack_full && flag_t1_q
      |=> flag_t1_q && pc_q == $past(pc_q) + 12'h001)
      else $error("interrupt taken with full stack");
   a_zero_flag : assert property (@(posedge ref_clk) disable iff (reset)
      run_slot && alu_go && !alu_to_mem |=> status_q[1] == (acc_q == 8'h00))
      else $error("zero flag disagrees with result");
endmodule

/* File: tb/pmvt_prog_tool.sv */
// Purpose: Serial programming tool model
// Assumes: Levels change on the falling ref_clk edge
// Notes:   Serial clock stands low outside frames
`timescale 1ns/100ps
module pmvt_prog_tool (
   // Clock
   input  wire logic ref_clk,
   // Programming pins
   output      logic external_reset_pin_n,
   output      logic prog_serial_clock_pin,
   output      logic tool_data,
   output      logic tool_oe,
   input  wire logic prog_serial_data_pin_i
);
   initial
   begin
      external_reset_pin_n = 1'b1;
      prog_serial_clock_pin = 1'b0;
      tool_data = 1'b1;
      tool_oe = 1'b0;
   end
   // One frame: flag, 12 address bits, 15 data bits, MSB first
   task automatic frame(input logic wr, input logic [11:0] a, input logic [14:0] d, output logic [14:0] q);
      logic [27:0] f;
      f = {wr, a, d};
      q = 15'h0000;
      // Let an edge see the released reset pin between back-to-back frames
      @(negedge ref_clk);
      external_reset_pin_n = 1'b0;
      tool_oe = 1'b1;
      for (int i = 27; i >= 0; i--)
      begin
         // Hand the pin over after the address on a read
         if (!wr && i == 14) tool_oe = 1'b0;
         tool_data = f[i];
         repeat (4) @(negedge ref_clk);
         prog_serial_clock_pin = 1'b1;
         q = {q[13:0], prog_serial_data_pin_i};
         repeat (4) @(negedge ref_clk);
         prog_serial_clock_pin = 1'b0;
      end
      tool_oe = 1'b0;
      repeat (4) @(negedge ref_clk);
      external_reset_pin_n = 1'b1;
   endtask
endmodule

/* File: tb/test_program_memory_vector_table_unit.sv */
// Purpose: Self-checking bench of the program memory and vector unit
// Assumes: Tool model loads program words first
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
module test_program_memory_vector_table_unit;
   import pmvt_pkg::*;
   logic ref_clk = 0, reset = 1, dm_we = 0, alu_go = 0, alu_to_mem = 0, ext_int_n = 1;
   logic ext_int_en = 0, tmr0_ovf = 0, tmr0_int_en = 0, tmr1_ovf = 0, tmr1_int_en = 0;
   pmvt_op_t op = PMVT_OP_NEXT;
   pmvt_alu_t alu_op = PMVT_ALU_ADD;
   logic [11:0] op_addr = 12'h000, pc_q;
   logic [7:0] op_dest = 8'h00, dm_addr = 8'h00, dm_wdata = 8'h00, alu_dest = 8'h00, dm_rdata_q, acc_q;
   logic [14:0] fetch_word_q, q;
   logic [3:0] status_q;
   logic cyc_en, busy, rst_n, sclk, t_d, t_oe, d_o, d_oe, d_pin;
   int bad_count = 0, compares = 0;
   // Pin level: device, then tool, else the pull-high
   assign d_pin = d_oe ? d_o : (t_oe ? t_d : 1'b1);
   always #4 ref_clk = ~ref_clk;
   pmvt_top i_pmvt_top (.ref_clk, .reset, .op, .op_addr, .op_dest, .cyc_en, .busy, .pc_q, .fetch_word_q,
      .dm_we, .dm_addr, .dm_wdata, .dm_rdata_q, .alu_go, .alu_op, .alu_to_mem, .alu_dest, .acc_q,
      .status_q, .ext_int_n, .ext_int_en, .tmr0_ovf, .tmr0_int_en, .tmr1_ovf, .tmr1_int_en,
      .external_reset_pin_n(rst_n), .prog_serial_clock_pin(sclk), .prog_serial_data_pin_i(d_pin),
      .prog_serial_data_pin_o(d_o), .prog_serial_data_pin_oe(d_oe));
   pmvt_prog_tool i_pmvt_prog_tool (.ref_clk, .external_reset_pin_n(rst_n), .prog_serial_clock_pin(sclk),
      .tool_data(t_d), .tool_oe(t_oe), .prog_serial_data_pin_i(d_pin));
   task automatic conclude;
      $display("counts: %0d compares, %0d bad", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [14:0] e, input logic [14:0] s);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic do_reset;
      reset = 1;
      repeat (10) @(negedge ref_clk);
      reset = 0;
      chk("pc after reset", 15'h000, 15'(pc_q));
   endtask
   // Wait for an edge that takes a command
   task automatic slot;
      int n = 0;
      while (!(cyc_en === 1'b1 && busy === 1'b0) && n < 40) begin @(negedge ref_clk); n++; end
      if (n >= 40) chk("slot", 15'h1, 15'h0);
   endtask
   task automatic cmd(input pmvt_op_t o, input logic [11:0] a, input logic [7:0] d);
      slot;
      op = o; op_addr = a; op_dest = d;
      @(negedge ref_clk);
      op = PMVT_OP_NEXT;
   endtask
   task automatic dmw(input logic [7:0] a, input logic [7:0] d);
      slot;
      dm_we = 1; dm_addr = a; dm_wdata = d;
      @(negedge ref_clk);
      dm_we = 0;
   endtask
   task automatic dmr(input string n, input logic [7:0] a, input logic [6:0] e);
      dm_addr = a;
      // A write landing on the next edge shows in the read register one clock later
      repeat (2) @(negedge ref_clk);
      chk(n, 15'(e), 15'(dm_rdata_q[6:0]));
   endtask
   // Wait until the counter leaves the high area, then judge where it landed
   task automatic wait_pc(input logic [11:0] e);
      int n = 0;
      while (pc_q[11:4] !== 8'h00 && n < 200) begin @(negedge ref_clk); n++; end
      chk("vector", 15'(e), 15'(pc_q));
   endtask
   task automatic t_prog;
      i_pmvt_prog_tool.frame(1'b1, 12'hf06, 15'h5a1b, q);
      i_pmvt_prog_tool.frame(1'b1, 12'h020, 15'h7f3c, q);
      i_pmvt_prog_tool.frame(1'b0, 12'hf06, 15'h0000, q);
      chk("serial read", 15'h5a1b, q);
      chk("pc after reset pin", 15'h000, 15'(pc_q));
      $display("done: programming");
   endtask
   task automatic t_table;
      dmw(PMVT_ADDR_TABLE_PTR, 8'h06);
      cmd(PMVT_OP_TABLE_READ_LAST, 12'h000, 8'h60);
      chk("busy c1", 15'h1, 15'(busy));
      repeat (3) @(negedge ref_clk);
      chk("busy c4", 15'h1, 15'(busy));
      @(negedge ref_clk);
      chk("busy c5", 15'h0, 15'(busy));
      dmr("low byte", 8'h60, 7'h1b);
      dmr("latch", PMVT_ADDR_TABLE_HIGH, 7'h5a);
      dmw(PMVT_ADDR_TABLE_HIGH, 8'h00);
      dmr("latch kept", PMVT_ADDR_TABLE_HIGH, 7'h5a);
      dmw(PMVT_ADDR_TABLE_PTR, 8'h20);
      cmd(PMVT_OP_TABLE_READ_CURRENT, 12'h000, 8'h61);
      repeat (4) @(negedge ref_clk);
      dmr("current page", 8'h61, 7'h3c);
      $display("done: table reads");
   endtask
   task automatic t_jump;
      cmd(PMVT_OP_JUMP, 12'h020, 8'h00);
      repeat (4) @(negedge ref_clk);
      chk("fetch word", 15'h7f3c, fetch_word_q);
      cmd(PMVT_OP_JUMP, 12'h345, 8'h00);
      dmw(PMVT_ADDR_PC_LOW, 8'h12);
      chk("low byte jump", 15'h312, 15'(pc_q));
      chk("dummy cycle", 15'h1, 15'(busy));
      cmd(PMVT_OP_SKIP, 12'h000, 8'h00);
      chk("skip", 15'h314, 15'(pc_q));
      $display("done: jumps");
   endtask
   task automatic t_alu;
      dmw(8'h62, 8'hc0);
      for (int i = 0; i < 3; i++)
      begin
         slot;
         alu_go = 1; alu_op = PMVT_ALU_ADD; alu_dest = 8'h62; alu_to_mem = (i == 2);
         @(negedge ref_clk);
         alu_go = 0;
      end
      chk("acc", 15'h080, 15'(acc_q));
      chk("carry", 15'h1, 15'(status_q[0]));
      dmr("alu to memory", 8'h62, 7'h40);
      $display("done: alu");
   endtask
   task automatic t_int;
      logic [11:0] v[3];
      v = '{PMVT_VEC_EXT, PMVT_VEC_TMR0, PMVT_VEC_TMR1};
      {tmr1_int_en, tmr0_int_en, ext_int_en} = 3'b111;
      for (int i = 0; i < 3; i++)
      begin
         do_reset;
         cmd(PMVT_OP_JUMP, 12'h800, 8'h00);
         ext_int_n = (i != 0); tmr0_ovf = (i <= 1); tmr1_ovf = 1;
         @(negedge ref_clk);
         ext_int_n = 1; tmr0_ovf = 0; tmr1_ovf = 0;
         wait_pc(v[i]);
      end
      do_reset;
      repeat (6) cmd(PMVT_OP_CALL, 12'h800, 8'h00);
      tmr1_ovf = 1;
      @(negedge ref_clk);
      tmr1_ovf = 0;
      repeat (40) @(negedge ref_clk);
      chk("held while full", 15'h1, 15'(pc_q[11]));
      cmd(PMVT_OP_RETURN, 12'h000, 8'h00);
      wait_pc(PMVT_VEC_TMR1);
      $display("done: interrupts");
   endtask
   initial
   begin
      do_reset;
      t_prog;
      t_table;
      t_jump;
      do_reset;
      t_alu;
      t_int;
      conclude;
   end
   // Watchdog well past the expected run length
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      conclude;
   end
endmodule
